// ### logic/dac_timing_pkg.sv
// constants shared by the serial word timing block and its buffer
// assumes one converter word of 16 bits and a host that frames words one shift clock early
package dac_timing_pkg;
    localparam int WORD_BITS = 16;
    localparam int MIXED_MODE_BIT_POS = 15;
    localparam int FIFO_DEPTH = 8;
    localparam int DEF_SAMPLE_CYCLES = 1024;
    localparam int DEF_ADV_STEP_CYCLES = 16;
    localparam int ADV_W = 4;
    localparam int DEV_CNT_W = 3;
    localparam int BIT_CNT_W = 5;
    localparam logic [BIT_CNT_W-1:0] BITS_PER_WORD = 5'h10;
    localparam logic [15:0] RST_WORD = 16'h0000;
endpackage

// ### logic/word_fifo.sv
// synchronous valid/ready buffer for converter words
// assumes both sides run on the same clock
module word_fifo #(
    parameter int WIDTH = dac_timing_pkg::WORD_BITS,
    parameter int DEPTH = dac_timing_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
            $error("word_fifo: depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    logic push;
    logic pop;

    assign o_in_ready = count_reg != (PW+1)'(DEPTH);
    assign o_out_valid = count_reg != '0;
    assign push = i_in_valid && o_in_ready;
    assign pop = i_out_ready && o_out_valid;
    assign o_out_data = mem[rd_ptr_reg];

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push && !pop) count_reg <= count_reg + 1'b1;
            else if (pop && !push) count_reg <= count_reg - 1'b1;
        end
    end
endmodule // word_fifo

// ### logic/dac_load_timing_control.sv
// converter serial word timing: adc word out, dac word in, timed dac load
// assumes the host frames each word one shift clock before its first bit, msb first
//
// Function
// R1 - with no advance, dac loads from dac register just before output frame sync rises
// R2 - dac load instant can move earlier than output frame sync by a set amount
// R3 - output frame sync pulse marks a new adc word ready for the host
// R4 - after frame sync, adc word leaves msb first over exactly 16 shift clocks
// R5 - completed 16 bit input word goes to dac register, drives dac at load instant
// R6 - host-programmed advance setting selects how early the dac is loaded
// R7 - in mixed mode a set top bit marks control words, clear marks dac data
// R8 - in a cascade the dac updates after device-count dac word frame syncs
module dac_load_timing_control #(
    parameter int SAMPLE_CYCLES = dac_timing_pkg::DEF_SAMPLE_CYCLES,
    parameter int ADV_STEP = dac_timing_pkg::DEF_ADV_STEP_CYCLES,
    parameter int FIFO_DEPTH = dac_timing_pkg::FIFO_DEPTH
) (
    // clocks and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_sclk,
    // configuration
    input wire logic [dac_timing_pkg::ADV_W-1:0] i_dac_advance,
    input wire logic i_mixed_mode_bit,
    input wire logic [dac_timing_pkg::DEV_CNT_W-1:0] i_device_count,
    // adc word stream
    input wire logic i_adc_valid,
    input wire logic [15:0] i_adc_data,
    output logic o_adc_ready,
    // dac and control outputs
    output logic [15:0] o_dac_data,
    output logic o_dac_load,
    output logic [15:0] o_ctrl_word,
    output logic o_ctrl_valid,
    // serial link
    input wire logic i_serial_in_frame_sync,
    input wire logic i_serial_data_in,
    output logic o_serial_out_frame_sync,
    output logic o_serial_data_out
);
    localparam int CW = $clog2(SAMPLE_CYCLES);
    localparam int MSB = dac_timing_pkg::MIXED_MODE_BIT_POS;
    localparam logic [CW-1:0] LAST = CW'(SAMPLE_CYCLES - 1);

    initial begin
        if (SAMPLE_CYCLES < 4 || ADV_STEP < 1 ||
            (2 ** dac_timing_pkg::ADV_W - 1) * ADV_STEP >= SAMPLE_CYCLES)
            $error("dac_load_timing_control: advance range exceeds sample period");
    end

    function automatic logic [CW-1:0] load_point(input logic [dac_timing_pkg::ADV_W-1:0] adv);
        load_point = LAST - CW'(32'(adv) * ADV_STEP);
    endfunction

    // reference domain
    logic [CW-1:0] sample_cnt_reg;
    logic frame_tick;
    logic load_tick;
    logic fifo_valid;
    logic [15:0] fifo_data;
    logic pop;
    logic tx_busy;
    logic tx_req_tgl_reg;
    logic [15:0] tx_hold_reg;
    logic ack_s1_reg, ack_s2_reg;
    logic rx_s1_reg, rx_s2_reg, rx_s3_reg;
    logic rx_evt;
    logic [15:0] dac_reg;
    logic [15:0] dac_out_reg;
    logic dac_load_reg;
    logic [15:0] ctrl_reg;
    logic ctrl_valid_reg;
    // link domain
    logic req_s1_reg, req_s2_reg, req_s3_reg;
    logic tx_ack_tgl_reg;
    logic [15:0] tx_shift_reg;
    logic [dac_timing_pkg::BIT_CNT_W-1:0] tx_cnt_reg;
    logic sofs_reg;
    logic sdo_reg;
    logic [dac_timing_pkg::BIT_CNT_W-1:0] rx_cnt_reg;
    logic [15:0] rx_shift_reg;
    logic [15:0] rx_full;
    logic rx_done;
    logic rx_is_ctrl;
    logic [15:0] rx_hold_reg;
    logic rx_kind_reg;
    logic rx_tgl_reg;
    logic [dac_timing_pkg::DEV_CNT_W-1:0] dev_cnt_reg;
    logic mm_s1_reg, mm_s2_reg;
    logic [dac_timing_pkg::DEV_CNT_W-1:0] devc_s1_reg, devc_s2_reg;

    word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_adc_fifo (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(i_adc_valid),
        .i_in_data(i_adc_data),
        .o_in_ready(o_adc_ready),
        .o_out_valid(fifo_valid),
        .o_out_data(fifo_data),
        .i_out_ready(pop)
    );

    assign frame_tick = sample_cnt_reg == LAST;
    assign load_tick = sample_cnt_reg == load_point(i_dac_advance); // [R2] [R6]
    assign tx_busy = tx_req_tgl_reg ^ ack_s2_reg;
    // a word still shifting holds the buffer back; that frame is skipped
    assign pop = frame_tick && fifo_valid && !tx_busy;
    assign rx_evt = rx_s2_reg ^ rx_s3_reg;

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) sample_cnt_reg <= '0;
        else if (frame_tick) sample_cnt_reg <= '0;
        else sample_cnt_reg <= sample_cnt_reg + 1'b1;
    end

    // adc word handed to the link domain by toggle, held until acknowledged
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tx_req_tgl_reg <= 1'b0;
            tx_hold_reg <= dac_timing_pkg::RST_WORD;
        end else if (pop) begin
            tx_req_tgl_reg <= ~tx_req_tgl_reg; // [R3]
            tx_hold_reg <= fifo_data;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
            rx_s1_reg <= 1'b0;
            rx_s2_reg <= 1'b0;
            rx_s3_reg <= 1'b0;
        end else begin
            ack_s1_reg <= tx_ack_tgl_reg;
            ack_s2_reg <= ack_s1_reg;
            rx_s1_reg <= rx_tgl_reg;
            rx_s2_reg <= rx_s1_reg;
            rx_s3_reg <= rx_s2_reg;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dac_reg <= dac_timing_pkg::RST_WORD;
            ctrl_reg <= dac_timing_pkg::RST_WORD;
            ctrl_valid_reg <= 1'b0;
        end else begin
            ctrl_valid_reg <= rx_evt && rx_kind_reg; // [R7]
            if (rx_evt && rx_kind_reg) ctrl_reg <= rx_hold_reg;
            if (rx_evt && !rx_kind_reg) dac_reg <= rx_hold_reg; // [R5]
        end
    end

    // with zero advance this fires on the frame tick, ahead of the frame sync
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dac_out_reg <= dac_timing_pkg::RST_WORD;
            dac_load_reg <= 1'b0;
        end else begin
            dac_load_reg <= load_tick; // [R1]
            if (load_tick) dac_out_reg <= dac_reg; // [R1] [R5]
        end
    end

    assign o_dac_data = dac_out_reg;
    assign o_dac_load = dac_load_reg;
    assign o_ctrl_word = ctrl_reg;
    assign o_ctrl_valid = ctrl_valid_reg;

    // link domain: transmit
    always_ff @(posedge i_sclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            req_s3_reg <= 1'b0;
            mm_s1_reg <= 1'b0;
            mm_s2_reg <= 1'b0;
            devc_s1_reg <= '0;
            devc_s2_reg <= '0;
        end else begin
            req_s1_reg <= tx_req_tgl_reg;
            req_s2_reg <= req_s1_reg;
            req_s3_reg <= req_s2_reg;
            mm_s1_reg <= i_mixed_mode_bit;
            mm_s2_reg <= mm_s1_reg;
            devc_s1_reg <= i_device_count;
            devc_s2_reg <= devc_s1_reg;
        end
    end

    always_ff @(posedge i_sclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sofs_reg <= 1'b0;
            sdo_reg <= 1'b0;
            tx_cnt_reg <= '0;
            tx_shift_reg <= dac_timing_pkg::RST_WORD;
            tx_ack_tgl_reg <= 1'b0;
        end else begin
            sofs_reg <= 1'b0;
            if (req_s2_reg ^ req_s3_reg) begin
                sofs_reg <= 1'b1; // [R3]
                tx_shift_reg <= tx_hold_reg;
                tx_cnt_reg <= dac_timing_pkg::BITS_PER_WORD;
                sdo_reg <= 1'b0;
            end else if (tx_cnt_reg != '0) begin
                sdo_reg <= tx_shift_reg[15]; // [R4]
                tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
                tx_cnt_reg <= tx_cnt_reg - 1'b1; // [R4]
                if (tx_cnt_reg == 5'h01) tx_ack_tgl_reg <= ~tx_ack_tgl_reg;
            end else begin
                sdo_reg <= 1'b0;
            end
        end
    end

    assign o_serial_out_frame_sync = sofs_reg;
    assign o_serial_data_out = sdo_reg;

    // link domain: receive
    assign rx_full = {rx_shift_reg[14:0], i_serial_data_in};
    assign rx_done = rx_cnt_reg == 5'h01;
    assign rx_is_ctrl = mm_s2_reg && rx_full[MSB]; // [R7]

    always_ff @(posedge i_sclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rx_cnt_reg <= '0;
            rx_shift_reg <= dac_timing_pkg::RST_WORD;
        end else if (rx_cnt_reg != '0) begin
            rx_shift_reg <= rx_full;
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
        end else if (i_serial_in_frame_sync) begin
            rx_cnt_reg <= dac_timing_pkg::BITS_PER_WORD;
        end
    end

    // only dac words advance the cascade count; control words pass at once
    always_ff @(posedge i_sclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dev_cnt_reg <= '0;
            rx_tgl_reg <= 1'b0;
            rx_kind_reg <= 1'b0;
            rx_hold_reg <= dac_timing_pkg::RST_WORD;
        end else if (rx_done) begin
            if (rx_is_ctrl) begin
                rx_kind_reg <= 1'b1; // [R7]
                rx_hold_reg <= rx_full;
                rx_tgl_reg <= ~rx_tgl_reg;
            end else if (dev_cnt_reg == devc_s2_reg) begin
                dev_cnt_reg <= '0; // [R8]
                rx_kind_reg <= 1'b0;
                rx_hold_reg <= rx_full; // [R5]
                rx_tgl_reg <= ~rx_tgl_reg;
            end else begin
                dev_cnt_reg <= dev_cnt_reg + 1'b1; // [R8]
            end
        end
    end

    // checks, reference domain
    chk_default_load_point: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R1]
        (frame_tick && i_dac_advance == '0) |=> o_dac_load)
        else $error("dac not loaded on frame tick with zero advance");
    chk_advanced_load_time: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R2]
        o_dac_load |-> $past(sample_cnt_reg) == LAST - CW'(32'($past(i_dac_advance)) * ADV_STEP))
        else $error("dac load at wrong sample position");
    chk_advance_load_value: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R6]
        load_tick |=> o_dac_data == $past(dac_reg))
        else $error("dac output not taken from dac register");
    chk_dac_held_between: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R5]
        !load_tick |=> $stable(o_dac_data))
        else $error("dac output changed outside load instant");
    chk_rx_to_dac_reg: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [R5]
        (rx_evt && !rx_kind_reg) |=> dac_reg == $past(rx_hold_reg))
        else $error("received word not moved to dac register");
    // checks, link domain
    chk_frame_sync_pulse: assert property (@(posedge i_sclk) disable iff (i_sys_rst) // [R3]
        o_serial_out_frame_sync |=> !o_serial_out_frame_sync)
        else $error("output frame sync wider than one shift clock");
    chk_sixteen_bit_shift: assert property (@(posedge i_sclk) disable iff (i_sys_rst) // [R4]
        o_serial_out_frame_sync |-> ##15 (tx_cnt_reg == 5'h01) ##1 (tx_cnt_reg == 5'h00))
        else $error("adc word not shifted over sixteen clocks");
    chk_first_bit_msb: assert property (@(posedge i_sclk) disable iff (i_sys_rst) // [R4]
        o_serial_out_frame_sync |=> o_serial_data_out == $past(tx_shift_reg[15]))
        else $error("first bit out is not the msb");
    chk_ctrl_word_skip: assert property (@(posedge i_sclk) disable iff (i_sys_rst) // [R7]
        (rx_done && rx_is_ctrl) |=> $stable(dev_cnt_reg) && rx_kind_reg)
        else $error("control word counted as dac word");
    chk_cascade_count: assert property (@(posedge i_sclk) disable iff (i_sys_rst) // [R8]
        (rx_done && !rx_is_ctrl && dev_cnt_reg != devc_s2_reg) |=> $stable(rx_tgl_reg))
        else $error("dac word handed over before device count reached");

    cov_adc_frame: cover property (@(posedge i_sclk) disable iff (i_sys_rst)
        o_serial_out_frame_sync ##16 (tx_cnt_reg == 5'h00));
    cov_advanced_load: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        o_dac_load && i_dac_advance != '0);
    cov_ctrl_word: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst) o_ctrl_valid);
    cov_cascade_two: cover property (@(posedge i_sclk) disable iff (i_sys_rst)
        rx_done && !rx_is_ctrl && devc_s2_reg == 3'h1 && dev_cnt_reg == 3'h1);
endmodule // dac_load_timing_control

// ### tb/dsp_port_model.sv
// dsp serial port model: takes adc frames, sends words framed one shift clock early
// assumes a free-running shift clock from the bench, data sampled by the device on its rise
module dsp_port_model (
    // link clock and reset
    input wire logic i_sclk,
    input wire logic i_sys_rst,
    // from the device
    input wire logic i_serial_out_frame_sync,
    input wire logic i_serial_data_out,
    // to the device
    output logic o_serial_in_frame_sync,
    output logic o_serial_data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] rx_q[$];
    logic [15:0] shift_reg;
    int bits_left;
    initial begin
        o_serial_in_frame_sync = 1'b0;
        o_serial_data_in = 1'b0;
    end
    // 16 bits msb first follow each output frame sync
    always @(posedge i_sclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bits_left = 0;
        end else if (bits_left > 0) begin
            shift_reg = {shift_reg[14:0], i_serial_data_out};
            bits_left--;
            if (bits_left == 0) rx_q.push_back(shift_reg);
        end else if (i_serial_out_frame_sync === 1'b1) begin
            bits_left = 16;
        end
    end
    task automatic send_word(input logic [15:0] w);
        @(negedge i_sclk);
        o_serial_in_frame_sync = 1'b1;
        for (int i = 15; i >= 0; i--) begin
            @(negedge i_sclk);
            o_serial_in_frame_sync = 1'b0;
            o_serial_data_in = w[i];
        end
        // line is not held after the word: flip it so a late sample is caught
        @(negedge i_sclk);
        o_serial_data_in = ~w[0];
    endtask
endmodule // dsp_port_model

// ### tb/test_dac_load_timing_control.sv
// self-checking bench for the dac load timing block with a dsp port model
// assumes a shortened sample period; link clock free-running at 80 ns
module test_dac_load_timing_control;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int S = 256;
    localparam int STEP = 8;
    logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_sclk = 1'b0;
    logic [3:0] i_dac_advance = 4'h0;
    logic i_mixed_mode_bit = 1'b0, i_adc_valid = 1'b0;
    logic [2:0] i_device_count = 3'h0;
    logic [15:0] i_adc_data = 16'h0000;
    logic o_adc_ready, o_dac_load, o_ctrl_valid, fs_in, sd_in, fs_out, sd_out;
    logic [15:0] o_dac_data, o_ctrl_word, ctrl_seen, dac_prev, w, w2;
    logic [15:0] exp_q[$];
    int mismatches = 0, compares = 0, cyc = 0, t0, seed = 51680, prev_adv;
    int advs[5] = '{1, 7, 15, 3, 0};
    dac_load_timing_control #(.SAMPLE_CYCLES(S), .ADV_STEP(STEP), .FIFO_DEPTH(8)) dut (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_sclk(i_sclk),
        .i_dac_advance(i_dac_advance), .i_mixed_mode_bit(i_mixed_mode_bit),
        .i_device_count(i_device_count), .i_adc_valid(i_adc_valid),
        .i_adc_data(i_adc_data), .o_adc_ready(o_adc_ready), .o_dac_data(o_dac_data),
        .o_dac_load(o_dac_load), .o_ctrl_word(o_ctrl_word), .o_ctrl_valid(o_ctrl_valid),
        .i_serial_in_frame_sync(fs_in), .i_serial_data_in(sd_in),
        .o_serial_out_frame_sync(fs_out), .o_serial_data_out(sd_out));
    dsp_port_model dsp (.i_sclk(i_sclk), .i_sys_rst(i_sys_rst),
        .i_serial_out_frame_sync(fs_out), .i_serial_data_out(sd_out),
        .o_serial_in_frame_sync(fs_in), .o_serial_data_in(sd_in));
    initial forever #5 i_ref_clk = ~i_ref_clk;
    initial begin
        #13;
        forever #40 i_sclk = ~i_sclk;
    end
    always @(posedge i_ref_clk) cyc++;
    // cycles between two loads when the advance changes right after the first;
    // a smaller advance lands later in the same period, a larger one in the next
    function automatic int load_gap(input int prev, input int adv);
        int g;
        g = ((prev - adv) * STEP + S) % S;
        return (g == 0) ? S : g;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // returns at the falling edge where the load pulse stands
    task automatic wait_load();
        int k;
        for (k = 0; k < 2 * S; k++) begin
            @(negedge i_ref_clk);
            if (o_dac_load === 1'b1) break;
        end
        if (k == 2 * S) check(16'h0001, 16'h0000);
    endtask
    task automatic push(input logic [15:0] d);
        int k;
        @(negedge i_ref_clk);
        i_adc_valid = 1'b1;
        i_adc_data = d;
        for (k = 0; k < 16 * S && o_adc_ready !== 1'b1; k++) @(negedge i_ref_clk);
        exp_q.push_back(d);
        @(posedge i_ref_clk);
    endtask
    // dac data may only move in the cycle of a load pulse
    always @(negedge i_ref_clk) begin
        if (o_ctrl_valid === 1'b1) ctrl_seen = o_ctrl_word;
        if (i_sys_rst === 1'b0 && o_dac_load !== 1'b1) check(o_dac_data, dac_prev);
        dac_prev = o_dac_data;
    end
    initial begin
        #400000;
        mismatches++;
        test_done();
    end
    initial begin
        repeat (5) @(negedge i_ref_clk);
        repeat (2) @(posedge i_sclk);
        @(negedge i_ref_clk);
        i_sys_rst = 1'b0;
        check({o_adc_ready, o_dac_load, o_ctrl_valid, fs_out, sd_out, o_dac_data[10:0]},
            16'h8000);
        // advance moves the next load earlier by its step count
        wait_load();
        t0 = cyc;
        prev_adv = 0;
        foreach (advs[i]) begin
            i_dac_advance = 4'(advs[i]);
            wait_load();
            check(16'(cyc - t0), 16'(load_gap(prev_adv, advs[i])));
            t0 = cyc;
            prev_adv = advs[i];
        end
        // fill buffer right after a tick, see it refuse, then drain to the host
        wait_load();
        push(16'hffff);
        push(16'h0001);
        repeat (6) push(16'($random(seed)));
        @(negedge i_ref_clk);
        check({15'h0000, o_adc_ready}, 16'h0000);
        push(16'h8000);
        @(negedge i_ref_clk);
        i_adc_valid = 1'b0;
        for (int k = 0; k < 12 * S && dsp.rx_q.size() < 9; k++) @(negedge i_ref_clk);
        check(16'(dsp.rx_q.size()), 16'h0009);
        foreach (exp_q[i]) check(dsp.rx_q[i], exp_q[i]);
        // dac word waits in its register until the load instant
        wait_load();
        w = 16'($random(seed));
        dsp.send_word(w);
        check(o_dac_data, 16'h0000);
        wait_load();
        check(o_dac_data, w);
        // mixed mode: top bit set is a control word, clear is dac data
        i_mixed_mode_bit = 1'b1;
        wait_load();
        w2 = 16'($random(seed)) | 16'h8000;
        dsp.send_word(w2);
        wait_load();
        check(ctrl_seen, w2);
        check(o_dac_data, w);
        // cascade of two: the first dac word of a group must not reach the dac
        i_device_count = 3'h1;
        wait_load();
        w2 = 16'($random(seed)) & 16'h7fff;
        dsp.send_word(w2);
        wait_load();
        check(o_dac_data, w);
        w = 16'($random(seed)) & 16'h7fff;
        dsp.send_word(w);
        wait_load();
        check(o_dac_data, w);
        test_done();
    end
endmodule // test_dac_load_timing_control
